// [hw/mrb_meter_regs.sv]
// register bank for metering results, mode registers, flags, timeouts and peak detection
// assumes the serial decoder and the measurement datapath run on clk_sys_i, so no syncing
//
// Contract
// - line rate reads frequency, or period when accumulation config bit 7 set
// - measurement config bits 1:0 pick the phase feeding the rate estimate
// - waveform sample shows one of six inputs or power, chosen by bits 4:0
// - interrupt enable bits decide which pending flags pull the request low
// - clear-on-read view returns the flags and clears them; an event in the same cycle stays set
// - no zero crossing within the timeout raises that phase's flag; limit resets 0xFFFF
// - half-cycle count sets the accumulation length in half cycles; resets 0xFFFF
// - shared sag duration counts consecutive low half cycles; resets 0xFF
// - shared 8-bit sag threshold sets the sag detection level
// - monitored phase voltage above voltage peak threshold sets voltage peak flag
// - monitored phase current above current peak threshold sets current peak flag
// - voltage peak hold keeps the largest monitored phase voltage over the half-cycle count
// - thermal register holds the latest signed temperature result
// - energy formula config selects the energy formula; resets 0x1C
// - line accumulation config controls line accumulation; resets 0x78
// - measurement config picks period and peak channels; resets 0xFC
// - operating config holds general configuration; resets 4
// - waveform config sets channel and rate; resets zero
// - phase B and C voltage rms are signed 24-bit read-only, reset zero
`timescale 1ns/1ps
`default_nettype none

module mrb_meter_regs (
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // register port
  input wire logic [6:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [23:0] reg_wdata_i,
  output logic [23:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // measurement results
  input wire logic rms_valid_i,
  input wire logic [23:0] vrms_b_i,
  input wire logic [23:0] vrms_c_i,
  input wire logic temp_valid_i,
  input wire logic [7:0] temp_i,
  input wire logic [2:0][11:0] line_line_rate_estimate_i,
  input wire logic [2:0][11:0] line_period_i,
  // waveform samples, per phase
  input wire logic wave_valid_i,
  input wire logic [2:0][23:0] wave_curr_i,
  input wire logic [2:0][23:0] wave_volt_i,
  input wire logic [2:0][23:0] wave_pwr_i,
  // magnitudes for peak and sag detection
  input wire logic mag_valid_i,
  input wire logic [2:0][7:0] volt_mag_i,
  input wire logic [2:0][7:0] curr_mag_i,
  input wire logic [2:0] zero_cross_i,
  input wire logic half_cycle_i,
  // configuration to the datapath, interrupt
  output logic [7:0] operating_config_o,
  output logic [7:0] measurement_config_o,
  output logic [7:0] waveform_source_config_o,
  output logic [7:0] energy_formula_config_o,
  output logic [7:0] line_accum_config_o,
  output logic [15:0] half_cycle_count_o,
  output logic irq_n_o
);

  typedef struct packed {
    logic [23:0] vrms_b;
    logic [23:0] vrms_c;
    logic [11:0] line_rate;
    logic [7:0] thermal;
    logic [23:0] wave;
    logic [7:0] op_cfg;
    logic [7:0] meas_cfg;
    logic [7:0] wave_cfg;
    logic [7:0] formula_cfg;
    logic [7:0] accum_cfg;
    logic [23:0] irq_en;
    logic [23:0] flags;
    logic [15:0] zx_limit;
    logic [15:0] hc_count;
    logic [7:0] sag_cyc;
    logic [7:0] sag_lvl;
    logic [7:0] vpk_lvl;
    logic [7:0] ipk_lvl;
    logic [7:0] voltage_peak_hold;
    logic [7:0] voltage_peak_hold_run;
    logic [15:0] lc_cnt;
    logic [8:0] tick_cnt;
    logic [2:0][15:0] zx_cnt;
    logic [2:0][7:0] sag_cnt;
    logic [2:0][7:0] hc_max;
    logic [23:0] rdata;
    logic rvalid;
    logic irq_n;
  } mrb_state_s;

  mrb_state_s q;
  mrb_state_s d;
  logic [1:0] rst_sync_q;
  logic rst_q;
  logic wr_hit;
  logic rd_cor;
  logic tick;
  logic [23:0] flag_set;
  logic [2:0][7:0] hc_cur;
  logic [7:0] vpk_cur;
  logic [1:0] rate_sel;

  // reset release through two flops; assertion is immediate
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_sync_q <= 2'h0;
    end
    else if (ce_i)
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_q = rst_sync_q[1];

  // strobes shared by the next-state logic and the checks
  assign wr_hit = reg_wr_i;
  assign rd_cor = reg_rd_i && (reg_addr_i == mrb_pkg::ADDR_FLAGS_COR);
  assign tick = (q.tick_cnt == mrb_pkg::ZX_TICK_LAST);
  // phase select code 3 has no phase, so it falls back to phase A
  assign rate_sel = (q.meas_cfg[1:0] == 2'h3) ? 2'h0 : q.meas_cfg[1:0];

  // next state
  always_comb
  begin
    d = q;
    flag_set = 24'h0;
    vpk_cur = q.voltage_peak_hold_run;
    hc_cur = q.hc_max;

    if (rms_valid_i)
    begin
      d.vrms_b = vrms_b_i;
      d.vrms_c = vrms_c_i;
    end
    if (temp_valid_i)
    begin
      d.thermal = temp_i;
    end

    if (q.accum_cfg[mrb_pkg::ACCUM_PERIOD_BIT])
    begin
      d.line_rate = line_period_i[rate_sel];
    end
    else
    begin
      d.line_rate = line_line_rate_estimate_i[rate_sel];
    end

    if (wave_valid_i)
    begin
      d.wave = 24'h0;
      if (q.wave_cfg[1:0] != 2'h3)
      begin
        unique case (q.wave_cfg[4:mrb_pkg::WAVE_TYPE_LSB])
          mrb_pkg::WAVE_TYPE_CURR: d.wave = wave_curr_i[q.wave_cfg[1:0]];
          mrb_pkg::WAVE_TYPE_VOLT: d.wave = wave_volt_i[q.wave_cfg[1:0]];
          mrb_pkg::WAVE_TYPE_PWR: d.wave = wave_pwr_i[q.wave_cfg[1:0]];
          default: d.wave = 24'h0;
        endcase
      end
    end

    // zero-cross timeout prescaler
    d.tick_cnt = tick ? 9'h0 : q.tick_cnt + 9'h1;

    for (int i = 0; i < 3; i++)
    begin
      if (zero_cross_i[i])
      begin
        d.zx_cnt[i] = q.zx_limit;
      end
      else if (tick)
      begin
        if (q.zx_cnt[i] == 16'h0)
        begin
          flag_set[mrb_pkg::FLAG_ZX_TMO_LSB + i] = 1'b1;
          d.zx_cnt[i] = q.zx_limit;
        end
        else
        begin
          d.zx_cnt[i] = q.zx_cnt[i] - 16'h1;
        end
      end

      // half-cycle maximum, including a sample that lands on the boundary
      if (mag_valid_i && (volt_mag_i[i] > hc_cur[i]))
      begin
        hc_cur[i] = volt_mag_i[i];
      end
      d.hc_max[i] = hc_cur[i];

      if (mag_valid_i && q.meas_cfg[mrb_pkg::MEAS_PHASE_MON_LSB + i])
      begin
        if (volt_mag_i[i] > q.vpk_lvl)
        begin
          flag_set[mrb_pkg::FLAG_VOLTAGE_PEAK_HOLD] = 1'b1;
        end
        if (curr_mag_i[i] > q.ipk_lvl)
        begin
          flag_set[mrb_pkg::FLAG_IPEAK] = 1'b1;
        end
        if (volt_mag_i[i] > vpk_cur)
        begin
          vpk_cur = volt_mag_i[i];
        end
      end

      if (half_cycle_i)
      begin
        d.hc_max[i] = 8'h0;
        if (hc_cur[i] < q.sag_lvl)
        begin
          if (q.sag_cnt[i] != 8'hFF)
          begin
            d.sag_cnt[i] = q.sag_cnt[i] + 8'h1;
          end
          if ((q.sag_cnt[i] + 8'h1) == q.sag_cyc)
          begin
            flag_set[mrb_pkg::FLAG_SAG_LSB + i] = 1'b1;
          end
        end
        else
        begin
          d.sag_cnt[i] = 8'h0;
        end
      end
    end
    d.voltage_peak_hold_run = vpk_cur;

    if (half_cycle_i)
    begin
      if ((q.lc_cnt + 16'h1) >= q.hc_count)
      begin
        d.voltage_peak_hold = vpk_cur;
        d.voltage_peak_hold_run = 8'h0;
        d.lc_cnt = 16'h0;
        flag_set[mrb_pkg::FLAG_LINE_CYC] = 1'b1;
      end
      else
      begin
        d.lc_cnt = q.lc_cnt + 16'h1;
      end
    end

    // register writes; read-only offsets fall through untouched
    if (wr_hit)
    begin
      unique case (reg_addr_i)
        mrb_pkg::ADDR_OP_CFG: d.op_cfg = reg_wdata_i[7:0];
        mrb_pkg::ADDR_MEAS_CFG: d.meas_cfg = reg_wdata_i[7:0];
        mrb_pkg::ADDR_WAVE_CFG: d.wave_cfg = reg_wdata_i[7:0];
        mrb_pkg::ADDR_FORMULA_CFG: d.formula_cfg = reg_wdata_i[7:0];
        mrb_pkg::ADDR_ACCUM_CFG: d.accum_cfg = reg_wdata_i[7:0];
        mrb_pkg::ADDR_IRQ_EN: d.irq_en = reg_wdata_i;
        mrb_pkg::ADDR_ZX_LIMIT: d.zx_limit = reg_wdata_i[15:0];
        mrb_pkg::ADDR_HC_COUNT: d.hc_count = reg_wdata_i[15:0];
        mrb_pkg::ADDR_SAG_CYC: d.sag_cyc = reg_wdata_i[7:0];
        mrb_pkg::ADDR_SAG_LVL: d.sag_lvl = reg_wdata_i[7:0];
        mrb_pkg::ADDR_VPK_LVL: d.vpk_lvl = reg_wdata_i[7:0];
        mrb_pkg::ADDR_IPK_LVL: d.ipk_lvl = reg_wdata_i[7:0];
        default: d.op_cfg = d.op_cfg;
      endcase
    end

    // clear-on-read; a new event in the same cycle survives
    d.flags = (rd_cor ? 24'h0 : q.flags) | flag_set;

    // register reads answer one cycle later; unmapped offsets read zero
    d.rvalid = reg_rd_i;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        mrb_pkg::ADDR_PH_B_VRMS: d.rdata = q.vrms_b;
        mrb_pkg::ADDR_PH_C_VRMS: d.rdata = q.vrms_c;
        mrb_pkg::ADDR_LINE_RATE: d.rdata = {12'h0, q.line_rate};
        mrb_pkg::ADDR_THERMAL: d.rdata = {16'h0, q.thermal};
        mrb_pkg::ADDR_WAVE: d.rdata = q.wave;
        mrb_pkg::ADDR_OP_CFG: d.rdata = {16'h0, q.op_cfg};
        mrb_pkg::ADDR_MEAS_CFG: d.rdata = {16'h0, q.meas_cfg};
        mrb_pkg::ADDR_WAVE_CFG: d.rdata = {16'h0, q.wave_cfg};
        mrb_pkg::ADDR_FORMULA_CFG: d.rdata = {16'h0, q.formula_cfg};
        mrb_pkg::ADDR_ACCUM_CFG: d.rdata = {16'h0, q.accum_cfg};
        mrb_pkg::ADDR_IRQ_EN: d.rdata = q.irq_en;
        mrb_pkg::ADDR_FLAGS: d.rdata = q.flags;
        mrb_pkg::ADDR_FLAGS_COR: d.rdata = q.flags;
        mrb_pkg::ADDR_ZX_LIMIT: d.rdata = {8'h0, q.zx_limit};
        mrb_pkg::ADDR_HC_COUNT: d.rdata = {8'h0, q.hc_count};
        mrb_pkg::ADDR_SAG_CYC: d.rdata = {16'h0, q.sag_cyc};
        mrb_pkg::ADDR_SAG_LVL: d.rdata = {16'h0, q.sag_lvl};
        mrb_pkg::ADDR_VPK_LVL: d.rdata = {16'h0, q.vpk_lvl};
        mrb_pkg::ADDR_IPK_LVL: d.rdata = {16'h0, q.ipk_lvl};
        mrb_pkg::ADDR_VOLTAGE_PEAK_HOLD: d.rdata = {16'h0, q.voltage_peak_hold};
        default: d.rdata = 24'h0;
      endcase
    end

    // enabled pending flags drive the request low
    d.irq_n = ~(|(q.flags & q.irq_en));
  end

  // state register; the enable freezes everything
  always_ff @(posedge clk_sys_i or negedge rst_q)
  begin
    if (!rst_q)
    begin
      q <= '0;
      q.op_cfg <= mrb_pkg::OP_CFG_RST;
      q.meas_cfg <= mrb_pkg::MEAS_CFG_RST;
      q.wave_cfg <= mrb_pkg::WAVE_CFG_RST;
      q.formula_cfg <= mrb_pkg::FORMULA_CFG_RST;
      q.accum_cfg <= mrb_pkg::ACCUM_CFG_RST;
      q.zx_limit <= mrb_pkg::ZX_LIMIT_RST;
      q.hc_count <= mrb_pkg::HC_COUNT_RST;
      q.sag_cyc <= mrb_pkg::SAG_CYC_RST;
      q.sag_lvl <= mrb_pkg::SAG_LVL_RST;
      q.vpk_lvl <= mrb_pkg::VPK_LVL_RST;
      q.ipk_lvl <= mrb_pkg::IPK_LVL_RST;
      q.zx_cnt <= {3{mrb_pkg::ZX_LIMIT_RST}};
      q.irq_n <= 1'b1;
    end
    else if (ce_i)
    begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign reg_rdata_o = q.rdata;
  assign reg_rvalid_o = q.rvalid;
  assign operating_config_o = q.op_cfg;
  assign measurement_config_o = q.meas_cfg;
  assign waveform_source_config_o = q.wave_cfg;
  assign energy_formula_config_o = q.formula_cfg;
  assign line_accum_config_o = q.accum_cfg;
  assign half_cycle_count_o = q.hc_count;
  assign irq_n_o = q.irq_n;

  // checks; they expect ce_i high
  sequence seq_cor_read;
    ce_i && rd_cor && (flag_set == 24'h0);
  endsequence

  sequence seq_flags_empty;
    (q.flags == 24'h0) && q.rvalid;
  endsequence

  AST_COR_CLEARS: assert property (@(posedge clk_sys_i) disable iff (!rst_q)
    seq_cor_read |=> seq_flags_empty)
    else $error("clear-on-read left flags set");

  AST_COR_DATA: assert property (@(posedge clk_sys_i) disable iff (!rst_q)
    (ce_i && rd_cor) |=> (q.rdata == $past(q.flags)))
    else $error("clear-on-read returned wrong data");

  AST_IRQ_LOW: assert property (@(posedge clk_sys_i) disable iff (!rst_q)
    (ce_i && ((q.flags & q.irq_en) != 24'h0) && !rd_cor) |=> !irq_n_o)
    else $error("enabled flag did not pull request low");

  AST_ZX_TMO: assert property (@(posedge clk_sys_i) disable iff (!rst_q)
    (ce_i && tick && !zero_cross_i[0] && (q.zx_cnt[0] == 16'h0)) |=> q.flags[0])
    else $error("zero-cross timeout flag missing");

  AST_VOLTAGE_PEAK_HOLD_FLAG: assert property (@(posedge clk_sys_i) disable iff (!rst_q)
    (ce_i && mag_valid_i && q.meas_cfg[5] && (volt_mag_i[0] > q.vpk_lvl))
      |=> q.flags[mrb_pkg::FLAG_VOLTAGE_PEAK_HOLD])
    else $error("voltage peak flag missing");

  // unmonitored phases never raise the current peak flag
  AST_IPEAK_MON: assert property (@(posedge clk_sys_i) disable iff (!rst_q)
    (ce_i && mag_valid_i && (q.meas_cfg[7:5] == 3'h0) && !q.flags[mrb_pkg::FLAG_IPEAK])
      |=> !q.flags[mrb_pkg::FLAG_IPEAK])
    else $error("current peak flag set for unmonitored phase");

  AST_RO_WRITE: assert property (@(posedge clk_sys_i) disable iff (!rst_q)
    (ce_i && wr_hit && (reg_addr_i == mrb_pkg::ADDR_VOLTAGE_PEAK_HOLD) && !half_cycle_i)
      |=> $stable(q.voltage_peak_hold))
    else $error("write changed a read-only register");

  // period chosen when bit 7 set
  AST_RATE_KIND: assert property (@(posedge clk_sys_i) disable iff (!rst_q)
    (ce_i && q.accum_cfg[7] && (q.meas_cfg[1:0] == 2'h1))
      |=> (q.line_rate == $past(line_period_i[1])))
    else $error("line rate did not follow period select");

  // peak hold takes the window maximum
  AST_PEAK_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rst_q)
    (ce_i && half_cycle_i && (q.hc_count == 16'h1) && !mag_valid_i)
      |=> (q.voltage_peak_hold == $past(q.voltage_peak_hold_run)))
    else $error("peak hold missed window maximum");

endmodule : mrb_meter_regs

`default_nettype wire

// [hw/mrb_pkg.sv]
// constants for the metering register bank: offsets, reset values, field positions, timing
// assumes a 10 MHz system clock and a register port driven by the serial-port decoder
package mrb_pkg;

  // register offsets on the 7-bit register address
  localparam logic [6:0] ADDR_PH_B_VRMS = 7'h0E;
  localparam logic [6:0] ADDR_PH_C_VRMS = 7'h0F;
  localparam logic [6:0] ADDR_LINE_RATE = 7'h10;
  localparam logic [6:0] ADDR_THERMAL = 7'h11;
  localparam logic [6:0] ADDR_WAVE = 7'h12;
  localparam logic [6:0] ADDR_OP_CFG = 7'h13;
  localparam logic [6:0] ADDR_MEAS_CFG = 7'h14;
  localparam logic [6:0] ADDR_WAVE_CFG = 7'h15;
  localparam logic [6:0] ADDR_FORMULA_CFG = 7'h16;
  localparam logic [6:0] ADDR_ACCUM_CFG = 7'h17;
  localparam logic [6:0] ADDR_IRQ_EN = 7'h18;
  localparam logic [6:0] ADDR_FLAGS = 7'h19;
  localparam logic [6:0] ADDR_FLAGS_COR = 7'h1A;
  localparam logic [6:0] ADDR_ZX_LIMIT = 7'h1B;
  localparam logic [6:0] ADDR_HC_COUNT = 7'h1C;
  localparam logic [6:0] ADDR_SAG_CYC = 7'h1D;
  localparam logic [6:0] ADDR_SAG_LVL = 7'h1E;
  localparam logic [6:0] ADDR_VPK_LVL = 7'h1F;
  localparam logic [6:0] ADDR_IPK_LVL = 7'h20;
  localparam logic [6:0] ADDR_VOLTAGE_PEAK_HOLD = 7'h21;

  // reset values of the writable registers
  localparam logic [7:0] OP_CFG_RST = 8'h04;
  localparam logic [7:0] MEAS_CFG_RST = 8'hFC;
  localparam logic [7:0] WAVE_CFG_RST = 8'h00;
  localparam logic [7:0] FORMULA_CFG_RST = 8'h1C;
  localparam logic [7:0] ACCUM_CFG_RST = 8'h78;
  localparam logic [15:0] ZX_LIMIT_RST = 16'hFFFF;
  localparam logic [15:0] HC_COUNT_RST = 16'hFFFF;
  localparam logic [7:0] SAG_CYC_RST = 8'hFF;
  localparam logic [7:0] SAG_LVL_RST = 8'h00;
  localparam logic [7:0] VPK_LVL_RST = 8'hFF;
  localparam logic [7:0] IPK_LVL_RST = 8'hFF;

  // field positions
  localparam int ACCUM_PERIOD_BIT = 7;
  localparam int MEAS_PHASE_MON_LSB = 5;
  localparam int WAVE_TYPE_LSB = 2;
  localparam logic [2:0] WAVE_TYPE_CURR = 3'h0;
  localparam logic [2:0] WAVE_TYPE_VOLT = 3'h1;
  localparam logic [2:0] WAVE_TYPE_PWR = 3'h2;

  // interrupt flag positions
  localparam int FLAG_ZX_TMO_LSB = 0;
  localparam int FLAG_SAG_LSB = 3;
  localparam int FLAG_VOLTAGE_PEAK_HOLD = 6;
  localparam int FLAG_IPEAK = 7;
  localparam int FLAG_LINE_CYC = 8;

  // zero-cross timeout: full count of the limit register spans the longest timeout
  localparam int CLK_PERIOD_NS = 100;
  localparam longint ZX_MAX_NS = 64'd2300000000;
  localparam longint ZX_STEPS = 64'd65535;
  localparam int ZX_TICK_CYC = int'(ZX_MAX_NS / (ZX_STEPS * longint'(CLK_PERIOD_NS)));
  localparam logic [8:0] ZX_TICK_LAST = 9'(ZX_TICK_CYC - 1);

endpackage : mrb_pkg

// [tb/mrb_host_bfm.sv]
// host-side model of the register port: one write or read per call
// assumes the bench owns clock and reset and waits out reset before calling
`timescale 1ns/1ps
`default_nettype none

module mrb_host_bfm (
  // clock
  input wire logic clk_sys_i,
  // register port
  output logic [6:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [23:0] reg_wdata_o,
  input wire logic [23:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  // idle bus at time zero
  initial
  begin
    reg_addr_o = 7'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 24'h000000;
  end

  // one-cycle strobe; an idle cycle separates calls
  task automatic wr(input logic [6:0] a, input logic [23:0] dat);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_wdata_o <= dat;
    reg_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
  endtask : wr

  // bounded wait for the answer; a missing answer returns unknowns
  task automatic rd(input logic [6:0] a, output logic [23:0] dat);
    int n;
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0;
    n = 0;
    #1;
    while (reg_rvalid_i !== 1'b1 && n < 4)
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    dat = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 24'hXXXXXX;
  endtask : rd
endmodule : mrb_host_bfm

`default_nettype wire

// [tb/mrb_meter_regs_tb_top.sv]
// self-checking bench for the metering register bank
// assumes the host model owns the register port; datapath strobes come from here
`timescale 1ns/1ps
`default_nettype none

module mrb_meter_regs_tb_top;
  logic clk_sys_i;
  logic rst_n_i;
  logic [6:0] addr;
  logic wr, rd, rvalid, irq_n;
  logic [23:0] wdata, rdata, vb, vc, d, e;
  logic [4:0] stb;
  logic [7:0] tmp, op_c, ms_c, wv_c, fm_c, ac_c;
  logic [15:0] hc_c;
  logic [2:0][11:0] lf, lp;
  logic [2:0][23:0] wc, wv, wp;
  logic [2:0][7:0] vm, cm;
  logic [2:0] zx;
  logic [23:0] rv [20];
  logic [23:0] mk [20];
  int n_mismatch, n_compared, cyc;

  mrb_host_bfm i_mrb_host_bfm (
    .clk_sys_i(clk_sys_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

  // clock enable tied high: freezing is outside these tests
  mrb_meter_regs i_mrb_meter_regs (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .rms_valid_i(stb[0]), .vrms_b_i(vb), .vrms_c_i(vc),
    .temp_valid_i(stb[1]), .temp_i(tmp), .line_line_rate_estimate_i(lf), .line_period_i(lp),
    .wave_valid_i(stb[2]), .wave_curr_i(wc), .wave_volt_i(wv), .wave_pwr_i(wp),
    .mag_valid_i(stb[3]), .volt_mag_i(vm), .curr_mag_i(cm), .zero_cross_i(zx),
    .half_cycle_i(stb[4]), .operating_config_o(op_c), .measurement_config_o(ms_c),
    .waveform_source_config_o(wv_c), .energy_formula_config_o(fm_c),
    .line_accum_config_o(ac_c), .half_cycle_count_o(hc_c), .irq_n_o(irq_n));

  // 100 ns clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string nm, input logic [23:0] ex, input logic [23:0] got);
    n_compared++;
    if (got !== ex)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic rchk(input logic [6:0] a, input logic [23:0] ex);
    logic [23:0] v;
    i_mrb_host_bfm.rd(a, v);
    chk($sformatf("reg %h", a), ex, v);
  endtask : rchk

  // one-cycle datapath strobe: 0 rms, 1 temp, 2 wave, 3 mag, 4 half cycle
  task automatic pulse(input int b);
    @(posedge clk_sys_i);
    stb <= 5'h01 << b;
    @(posedge clk_sys_i);
    stb <= 5'h00;
  endtask : pulse

  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask : tend

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  // hang guard, well above the few thousand cycles the tests need
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  initial
  begin
    rst_n_i = 1'b0;
    stb = 5'h00;
    {vb, vc, tmp, lf, lp, wc, wv, wp, vm, cm, zx} = '0;
    rv = '{24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h04, 24'hFC, 24'h0, 24'h1C, 24'h78,
      24'h0, 24'h0, 24'h0, 24'hFFFF, 24'hFFFF, 24'hFF, 24'h0, 24'hFF, 24'hFF, 24'h0};
    mk = '{24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'hFF, 24'hFF, 24'hFF, 24'hFF, 24'hFF,
      24'hFFFFFF, 24'h0, 24'h0, 24'hFFFF, 24'hFFFF, 24'hFF, 24'hFF, 24'hFF, 24'hFF, 24'h0};
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    for (int i = 0; i < 20; i++)
      rchk(7'h0E + 7'(i), rv[i]);
    chk("cfg", 24'h04FC00, {op_c, ms_c, wv_c});
    chk("cfg2", 24'h1C78FF, {fm_c, ac_c, hc_c[7:0]});
    tend("reset");
    for (int i = 0; i < 20; i++)
      i_mrb_host_bfm.wr(7'h0E + 7'(i), 24'h5AA55A);
    for (int i = 0; i < 20; i++)
      rchk(7'h0E + 7'(i), mk[i] == 24'h0 ? rv[i] : 24'h5AA55A & mk[i]);
    chk("cfg", 24'h5AA55A, {ms_c, hc_c});
    i_mrb_host_bfm.wr(7'h22, 24'h123456);
    rchk(7'h22, 24'h0);
    rchk(7'h0D, 24'h0);
    tend("access");
    vb <= 24'h800001;
    vc <= 24'h7FFFFE;
    tmp <= 8'h9C;
    pulse(0);
    pulse(1);
    rchk(7'h0E, 24'h800001);
    rchk(7'h0F, 24'h7FFFFE);
    rchk(7'h11, 24'h00009C);
    tend("results");
    lf <= {12'h0C3, 12'h0B2, 12'h0A1};
    lp <= {12'h3C0, 12'h2B0, 12'h1A0};
    for (int s = 0; s < 4; s++)
      for (int p = 0; p < 2; p++)
      begin
        i_mrb_host_bfm.wr(7'h14, 24'(s));
        i_mrb_host_bfm.wr(7'h17, 24'(p * 128 + 120));
        rchk(7'h10, 24'(p ? lp[s % 3] : lf[s % 3]));
      end
    tend("rate");
    wc <= {24'hC00003, 24'hC00002, 24'hC00001};
    wv <= {24'h500003, 24'h500002, 24'h500001};
    wp <= {24'hA00003, 24'hA00002, 24'hA00001};
    for (int t = 0; t < 4; t++)
      for (int p = 0; p < 4; p++)
      begin
        i_mrb_host_bfm.wr(7'h15, 24'(t * 4 + p));
        pulse(2);
        e = (p == 3 || t == 3) ? 24'h0 : (t == 0) ? wc[p] : (t == 1) ? wv[p] : wp[p];
        rchk(7'h12, e);
      end
    tend("waveform");
    // peaks on monitored phase only, strictly above threshold
    i_mrb_host_bfm.wr(7'h18, 24'h000040);
    i_mrb_host_bfm.wr(7'h1F, 24'h40);
    i_mrb_host_bfm.wr(7'h20, 24'h40);
    i_mrb_host_bfm.wr(7'h14, 24'h20);
    vm <= {8'h7F, 8'h7F, 8'h40};
    cm <= {8'h7F, 8'h7F, 8'h40};
    pulse(3);
    rchk(7'h19, 24'h0);
    vm <= {8'h00, 8'h00, 8'h41};
    cm <= {8'h00, 8'h00, 8'h41};
    pulse(3);
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("irq", 24'h0, 24'(irq_n));
    rchk(7'h19, 24'h0000C0);
    rchk(7'h1A, 24'h0000C0);
    rchk(7'h19, 24'h0);
    chk("irq", 24'h1, 24'(irq_n));
    i_mrb_host_bfm.wr(7'h18, 24'h000000);
    pulse(3);
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk("irq", 24'h1, 24'(irq_n));
    rchk(7'h1A, 24'h0000C0);
    // unmonitored phases stay quiet even above both thresholds
    i_mrb_host_bfm.wr(7'h14, 24'h00);
    pulse(3);
    rchk(7'h19, 24'h0);
    tend("peak");
    // sag count and peak hold window; flush maxima left by the peak test first
    i_mrb_host_bfm.wr(7'h1E, 24'h00);
    i_mrb_host_bfm.wr(7'h1C, 24'h0002);
    pulse(4);
    pulse(4);
    rchk(7'h1A, 24'h000100);
    vm <= {8'h11, 8'h33, 8'h22};
    cm <= '0;
    i_mrb_host_bfm.wr(7'h1E, 24'h40);
    i_mrb_host_bfm.wr(7'h1D, 24'h02);
    i_mrb_host_bfm.wr(7'h1C, 24'h0002);
    i_mrb_host_bfm.wr(7'h14, 24'hE0);
    pulse(3);
    pulse(4);
    rchk(7'h19, 24'h0);
    vm <= {8'h10, 8'h20, 8'h30};
    pulse(3);
    pulse(4);
    rchk(7'h19, 24'h000138);
    rchk(7'h21, 24'h33);
    rchk(7'h1A, 24'h000138);
    // one-half-cycle window hands the running maximum straight to the hold
    i_mrb_host_bfm.wr(7'h1C, 24'h0001);
    pulse(3);
    pulse(4);
    rchk(7'h21, 24'h30);
    tend("sag");
    // zero-cross timeout, three ticks of 350 cycles after the crossing
    i_mrb_host_bfm.wr(7'h1B, 24'h0002);
    i_mrb_host_bfm.wr(7'h18, 24'h000007);
    @(posedge clk_sys_i);
    zx <= 3'h7;
    @(posedge clk_sys_i);
    zx <= 3'h0;
    repeat (300) @(posedge clk_sys_i);
    i_mrb_host_bfm.rd(7'h19, d);
    chk("zx early", 24'h0, d & 24'h7);
    repeat (1500) @(posedge clk_sys_i);
    i_mrb_host_bfm.rd(7'h19, d);
    chk("zx late", 24'h7, d & 24'h7);
    chk("irq", 24'h0, 24'(irq_n));
    tend("timeout");
    test_done();
  end
endmodule : mrb_meter_regs_tb_top

`default_nettype wire
